// >>> verilog/jtd_cfg.svh
// constants of the test access port: instruction codes, widths and pin sampling
//
// Function
// [R01] The port uses exactly four pins (test clock, mode select, data in, data out), driven and sampled by the host.
// [R02] Instruction and data register access follows the standard sixteen-state controller and its shift operations.
// [R03] The instruction register is 16 bits wide, resets to zero and selects the register between data in and data out.
// [R04] Three scan registers (boundary, identification, bypass) and four flash access registers are provided.
// [R05] Code 0x0000 selects the boundary register with control and observation of the pins.
// [R06] Code 0x0002 selects the boundary register for observing pins and presetting latches without driving.
// [R07] Code 0x0004 selects the identification register.
// [R08] Code 0xffff selects the one-stage bypass register.
// [R09] Code 0x0082 selects the flash control register that steers how flash data accesses behave.
// [R10] Code 0x0083 selects the flash data register whose accesses read and write the flash.
// [R11] Code 0x0084 selects the flash address register that holds the target of every flash operation.
// [R12] Code 0x0085 selects the flash scale register for the one-shot timer and read-always enable.
// [R13] The boundary register is a 134-bit shift register covering all pins, bus and pull-up enable.
// [R14] While the external-test instruction is active every input to core logic is forced to one.
// [R15] The identification instruction reaches a 32-bit identification register.
// [R16] Flash commands carry an operation in bits 19:18 (0x poll, 10 read, 11 write) and data in bits 17:0.
// [R17] Any undefined instruction code selects the bypass register.
`ifndef JTD_CFG_SVH
`define JTD_CFG_SVH

// ------------------------------------------------------------
// instruction codes
// ------------------------------------------------------------
`define JTD_IR_W          16
`define JTD_IR_RESET      16'h0000
`define JTD_IR_CAPTURE    16'h0001
`define JTD_IR_EXTEST     16'h0000
`define JTD_IR_SAMPLE     16'h0002
`define JTD_IR_IDCODE     16'h0004
`define JTD_IR_BYPASS     16'hffff
`define JTD_IR_FL_CTL     16'h0082
`define JTD_IR_FL_DAT     16'h0083
`define JTD_IR_FL_ADR     16'h0084
`define JTD_IR_FL_SCL     16'h0085

// ------------------------------------------------------------
// data register layout
// ------------------------------------------------------------
`define JTD_BSR_W         134
`define JTD_ID_W          32
// arbitrary neutral identification value
`define JTD_ID_VALUE      32'h0000_0001
`define JTD_IND_W         20
`define JTD_IND_DATA_W    18
`define JTD_OP_HI         19
`define JTD_OP_LO         18
`define JTD_OP_READ       2'h2
`define JTD_OP_WRITE      2'h3

// ------------------------------------------------------------
// pin sampling
// ------------------------------------------------------------
`define JTD_SYNC_STAGES   3

`endif

// >>> verilog/jtd_pkg.sv
// types shared by the test access port design
package jtd_pkg;

    typedef enum logic [3:0] {
        TLR  = 4'h0,
        RTI  = 4'h1,
        SDRS = 4'h2,
        CDR  = 4'h3,
        SDR  = 4'h4,
        E1DR = 4'h5,
        PDR  = 4'h6,
        E2DR = 4'h7,
        UDR  = 4'h8,
        SIRS = 4'h9,
        CIR  = 4'ha,
        SIR  = 4'hb,
        E1IR = 4'hc,
        PIR  = 4'hd,
        E2IR = 4'he,
        UIR  = 4'hf
    } jtd_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [17:0] wdata;
    } jtd_flash_req_t;

    typedef struct packed {
        logic [17:0] control;
        logic [17:0] address;
        logic [17:0] scale;
    } jtd_flash_regs_t;

endpackage

// >>> verilog/jtd_shift_reg.sv
// capture-and-shift stage clocked by detected test clock rising edges
module jtd_shift_reg #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // control
    input  wire logic         tck_rise,
    input  wire logic         capture,
    input  wire logic         shift,
    input  wire logic         serial_in,
    input  wire logic [W-1:0] capture_value,
    // result
    output logic      [W-1:0] value,
    output logic              serial_out
);

    logic [W-1:0] shifted;

    generate
        if (W == 1) begin : g_one
            assign shifted = serial_in;
        end else begin : g_many
            assign shifted = {serial_in, value[W-1:1]};
        end
    endgenerate

    assign serial_out = value[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= '0;
        end else if (tck_rise && capture) begin
            value <= capture_value;
        end else if (tck_rise && shift) begin
            value <= shifted;
        end
    end

endmodule

// >>> verilog/jtd_tap.sv
// test access port: controller, instruction decode and data registers
`include "jtd_cfg.svh"

module jtd_tap (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // link pins
    input  wire logic                           tck,
    input  wire logic                           tms,
    input  wire logic                           tdi,
    output logic                                tdo,
    output logic                                tdo_oe,
    // boundary cells
    input  wire logic [`JTD_BSR_W-1:0]          bsr_capture,
    output logic      [`JTD_BSR_W-1:0]          bsr_update,
    output logic                                pins_driven,
    output logic                                core_inputs_forced,
    // flash side
    input  wire logic [`JTD_IND_DATA_W-1:0]     flash_rdata,
    input  wire logic                           flash_busy,
    output jtd_pkg::jtd_flash_req_t             flash_req,
    output jtd_pkg::jtd_flash_regs_t            flash_regs,
    // status
    output logic      [`JTD_IR_W-1:0]           tap_instruction
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // [R01] three input pins sampled (clock, mode, data in)
    logic [2:0] pin_raw;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic [2:0] next_filt;

    assign pin_raw = {tdi, tms, tck};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            // a level counts only once stages two and three agree
            assign next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1[gi]   <= 1'b0;
                    s2[gi]   <= 1'b0;
                    s3[gi]   <= 1'b0;
                    filt[gi] <= 1'b0;
                end else begin
                    s1[gi]   <= pin_raw[gi];
                    s2[gi]   <= s1[gi];
                    s3[gi]   <= s2[gi];
                    filt[gi] <= next_filt[gi];
                end
            end
        end
    endgenerate

    wire tck_rise = next_filt[0] & ~filt[0];
    wire tck_fall = ~next_filt[0] & filt[0];
    wire tms_s    = next_filt[1];
    wire tdi_s    = next_filt[2];

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    jtd_pkg::jtd_state_t state;
    jtd_pkg::jtd_state_t next_state;

    // [R02] standard state sequence
    always_comb begin
        case (state)
            jtd_pkg::TLR:  next_state = tms_s ? jtd_pkg::TLR  : jtd_pkg::RTI;
            jtd_pkg::RTI:  next_state = tms_s ? jtd_pkg::SDRS : jtd_pkg::RTI;
            jtd_pkg::SDRS: next_state = tms_s ? jtd_pkg::SIRS : jtd_pkg::CDR;
            jtd_pkg::CDR:  next_state = tms_s ? jtd_pkg::E1DR : jtd_pkg::SDR;
            jtd_pkg::SDR:  next_state = tms_s ? jtd_pkg::E1DR : jtd_pkg::SDR;
            jtd_pkg::E1DR: next_state = tms_s ? jtd_pkg::UDR  : jtd_pkg::PDR;
            jtd_pkg::PDR:  next_state = tms_s ? jtd_pkg::E2DR : jtd_pkg::PDR;
            jtd_pkg::E2DR: next_state = tms_s ? jtd_pkg::UDR  : jtd_pkg::SDR;
            jtd_pkg::UDR:  next_state = tms_s ? jtd_pkg::SDRS : jtd_pkg::RTI;
            jtd_pkg::SIRS: next_state = tms_s ? jtd_pkg::TLR  : jtd_pkg::CIR;
            jtd_pkg::CIR:  next_state = tms_s ? jtd_pkg::E1IR : jtd_pkg::SIR;
            jtd_pkg::SIR:  next_state = tms_s ? jtd_pkg::E1IR : jtd_pkg::SIR;
            jtd_pkg::E1IR: next_state = tms_s ? jtd_pkg::UIR  : jtd_pkg::PIR;
            jtd_pkg::PIR:  next_state = tms_s ? jtd_pkg::E2IR : jtd_pkg::PIR;
            jtd_pkg::E2IR: next_state = tms_s ? jtd_pkg::UIR  : jtd_pkg::SIR;
            jtd_pkg::UIR:  next_state = tms_s ? jtd_pkg::SDRS : jtd_pkg::RTI;
            default:       next_state = jtd_pkg::TLR;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= jtd_pkg::TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    wire in_cdr  = (state == jtd_pkg::CDR);
    wire in_sdr  = (state == jtd_pkg::SDR);
    wire in_cir  = (state == jtd_pkg::CIR);
    wire in_sir  = (state == jtd_pkg::SIR);
    wire upd_dr  = tck_fall && (state == jtd_pkg::UDR);
    wire upd_ir  = tck_fall && (state == jtd_pkg::UIR);

    // ------------------------------------------------------------
    // instruction register and decode
    // ------------------------------------------------------------
    logic [`JTD_IR_W-1:0] ir_shift;
    logic                 ir_out;

    jtd_shift_reg #(.W(`JTD_IR_W)) u_ir (
        .clk           (clk),
        .rst           (rst),
        .tck_rise      (tck_rise),
        .capture       (in_cir),
        .shift         (in_sir),
        .serial_in     (tdi_s),
        .capture_value (`JTD_IR_CAPTURE),
        .value         (ir_shift),
        .serial_out    (ir_out)
    );

    // [R03] reset and test-logic-reset both clear the instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_instruction <= `JTD_IR_RESET;
        end else if (tck_fall && (state == jtd_pkg::TLR)) begin
            tap_instruction <= `JTD_IR_RESET;
        end else if (upd_ir) begin
            tap_instruction <= ir_shift;
        end
    end

    // [R05] external test
    wire sel_extest = (tap_instruction == `JTD_IR_EXTEST);
    // [R06] sample / preload
    wire sel_sample = (tap_instruction == `JTD_IR_SAMPLE);
    // [R07] identification
    wire sel_id     = (tap_instruction == `JTD_IR_IDCODE);
    // [R09] flash control
    wire sel_fctl   = (tap_instruction == `JTD_IR_FL_CTL);
    // [R10] flash data
    wire sel_fdat   = (tap_instruction == `JTD_IR_FL_DAT);
    // [R11] flash address
    wire sel_fadr   = (tap_instruction == `JTD_IR_FL_ADR);
    // [R12] flash scale
    wire sel_fscl   = (tap_instruction == `JTD_IR_FL_SCL);
    wire sel_bsr    = sel_extest | sel_sample;
    wire sel_ind    = sel_fctl | sel_fdat | sel_fadr | sel_fscl;
    // [R08] [R17] bypass for its own code and every undefined one
    wire sel_byp    = ~(sel_bsr | sel_id | sel_ind);

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic [`JTD_BSR_W-1:0] bsr_value;
    logic [`JTD_ID_W-1:0]  id_value;
    logic [`JTD_IND_W-1:0] ind_value;
    logic [`JTD_IND_W-1:0] ind_capture;
    logic                  byp_value;
    logic                  bsr_out;
    logic                  id_out;
    logic                  ind_out;
    logic                  byp_out;

    // [R04] [R13] 134-bit boundary register
    jtd_shift_reg #(.W(`JTD_BSR_W)) u_bsr (
        .clk           (clk),
        .rst           (rst),
        .tck_rise      (tck_rise),
        .capture       (in_cdr & sel_bsr),
        .shift         (in_sdr & sel_bsr),
        .serial_in     (tdi_s),
        .capture_value (bsr_capture),
        .value         (bsr_value),
        .serial_out    (bsr_out)
    );

    // [R15] 32-bit identification register
    jtd_shift_reg #(.W(`JTD_ID_W)) u_id (
        .clk           (clk),
        .rst           (rst),
        .tck_rise      (tck_rise),
        .capture       (in_cdr & sel_id),
        .shift         (in_sdr & sel_id),
        .serial_in     (tdi_s),
        .capture_value (`JTD_ID_VALUE),
        .value         (id_value),
        .serial_out    (id_out)
    );

    jtd_shift_reg #(.W(1)) u_byp (
        .clk           (clk),
        .rst           (rst),
        .tck_rise      (tck_rise),
        .capture       (in_cdr & sel_byp),
        .shift         (in_sdr & sel_byp),
        .serial_in     (tdi_s),
        .capture_value (1'b0),
        .value         (byp_value),
        .serial_out    (byp_out)
    );

    // one shared stage serves all four flash registers; only one is selected at a time
    jtd_shift_reg #(.W(`JTD_IND_W)) u_ind (
        .clk           (clk),
        .rst           (rst),
        .tck_rise      (tck_rise),
        .capture       (in_cdr & sel_ind),
        .shift         (in_sdr & sel_ind),
        .serial_in     (tdi_s),
        .capture_value (ind_capture),
        .value         (ind_value),
        .serial_out    (ind_out)
    );

    // [R09] data capture returns busy in the top bit so the host can poll
    assign ind_capture = sel_fctl ? {2'b00, flash_regs.control} :
                         sel_fadr ? {2'b00, flash_regs.address} :
                         sel_fscl ? {2'b00, flash_regs.scale}   :
                                    {flash_busy, 1'b0, flash_rdata};

    // ------------------------------------------------------------
    // boundary update and core forcing
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bsr_update <= '0;
        end else if (upd_dr && sel_bsr) begin
            bsr_update <= bsr_value;
        end
    end

    // [R05] [R06] only external test drives pins; sample just preloads
    assign pins_driven        = sel_extest;
    // [R14] core inputs held at one during external test
    assign core_inputs_forced = sel_extest;

    // ------------------------------------------------------------
    // flash command decode
    // ------------------------------------------------------------
    // [R16] operation field and write data
    wire [1:0]                  ind_op    = ind_value[`JTD_OP_HI:`JTD_OP_LO];
    wire [`JTD_IND_DATA_W-1:0]  ind_wdata = ind_value[`JTD_IND_DATA_W-1:0];
    wire                        op_write  = (ind_op == `JTD_OP_WRITE);
    wire                        op_read   = (ind_op == `JTD_OP_READ);
    wire                        ind_upd   = upd_dr && sel_ind;

    // [R11] [R12] holding registers loaded by write commands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_regs <= '0;
        end else if (ind_upd && op_write) begin
            if (sel_fctl) begin
                flash_regs.control <= ind_wdata;
            end
            if (sel_fadr) begin
                flash_regs.address <= ind_wdata;
            end
            if (sel_fscl) begin
                flash_regs.scale <= ind_wdata;
            end
        end
    end

    // [R10] data register read or write launches a one-cycle flash request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_req <= '0;
        end else begin
            flash_req.valid <= ind_upd && sel_fdat && (op_read || op_write);
            if (ind_upd && sel_fdat) begin
                flash_req.write <= op_write;
                flash_req.wdata <= ind_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // data out, changed on falling test clock
    // ------------------------------------------------------------
    wire dr_out = sel_bsr ? bsr_out :
                  sel_id  ? id_out  :
                  sel_ind ? ind_out : byp_out;

    // [R02] output valid only while shifting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= in_sir ? ir_out : dr_out;
            tdo_oe <= in_sir | in_sdr;
        end
    end

endmodule

// >>> sim/jtd_tap_props.sv
// concurrent checks on the ports of the test access port
`include "jtd_cfg.svh"

module jtd_tap_props (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // link pins
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    input  wire logic                       tdo,
    input  wire logic                       tdo_oe,
    // boundary cells
    input  wire logic [`JTD_BSR_W-1:0]      bsr_capture,
    input  wire logic [`JTD_BSR_W-1:0]      bsr_update,
    input  wire logic                       pins_driven,
    input  wire logic                       core_inputs_forced,
    // flash side
    input  wire logic [`JTD_IND_DATA_W-1:0] flash_rdata,
    input  wire logic                       flash_busy,
    input  jtd_pkg::jtd_flash_req_t         flash_req,
    input  jtd_pkg::jtd_flash_regs_t        flash_regs,
    // status
    input  wire logic [`JTD_IR_W-1:0]       tap_instruction
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_req_pulse;
        flash_req.valid ##1 !flash_req.valid;
    endsequence

    property p_rst_ir;
        $fell(rst) |-> tap_instruction == 16'h0000 && !tdo_oe && flash_regs == '0;
    endproperty
    property p_extest;
        pins_driven == (tap_instruction == 16'h0000) && core_inputs_forced == pins_driven;
    endproperty
    property p_req_pulse;
        flash_req.valid |-> s_req_pulse;
    endproperty
    property p_req_ir;
        flash_req.valid |-> tap_instruction == 16'h0083;
    endproperty
    property p_ctl;
        $changed(flash_regs.control) |-> tap_instruction == 16'h0082;
    endproperty
    property p_adr;
        $changed(flash_regs.address) |-> tap_instruction == 16'h0084;
    endproperty
    property p_scl;
        $changed(flash_regs.scale) |-> tap_instruction == 16'h0085;
    endproperty
    property p_bsr;
        $changed(bsr_update) |-> tap_instruction == 16'h0000 || tap_instruction == 16'h0002;
    endproperty
    // updates land only in the low phase, after a falling link edge
    property p_ir_edge;
        $changed(tap_instruction) |-> !$past(tck, 2);
    endproperty
    property p_oe_edge;
        $changed(tdo_oe) |-> !$past(tck, 2);
    endproperty
    property p_tdo_edge;
        $changed(tdo) |-> !$past(tck, 2);
    endproperty

    a_rst_ir: assert property (p_rst_ir)
        else $error("instruction or outputs not cleared by reset");
    a_extest: assert property (p_extest)
        else $error("pin drive or input forcing disagrees with instruction");
    a_req_pulse: assert property (p_req_pulse)
        else $error("flash request longer than one cycle");
    a_req_ir: assert property (p_req_ir)
        else $error("flash request without data instruction");
    a_ctl: assert property (p_ctl)
        else $error("control register written under wrong instruction");
    a_adr: assert property (p_adr)
        else $error("address register written under wrong instruction");
    a_scl: assert property (p_scl)
        else $error("scale register written under wrong instruction");
    a_bsr: assert property (p_bsr)
        else $error("boundary update under non-boundary instruction");
    a_ir_edge: assert property (p_ir_edge)
        else $error("instruction changed outside low phase");
    a_oe_edge: assert property (p_oe_edge)
        else $error("output enable changed outside low phase");
    a_tdo_edge: assert property (p_tdo_edge)
        else $error("data out changed outside low phase");
endmodule

bind jtd_tap jtd_tap_props i_jtd_tap_props (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .bsr_capture(bsr_capture), .bsr_update(bsr_update), .pins_driven(pins_driven),
    .core_inputs_forced(core_inputs_forced), .flash_rdata(flash_rdata),
    .flash_busy(flash_busy), .flash_req(flash_req), .flash_regs(flash_regs),
    .tap_instruction(tap_instruction)
);

// >>> sim/jtd_host_model.sv
// link host model: makes the test clock only while a tick runs (scans and navigation)
module jtd_host_model (
    // link pins
    output logic            tck,
    output logic            tms,
    output logic            tdi,
    input  wire logic       tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ------------------------------------------------------------
    // one link period: 100 ns low, 100 ns high, pins move on falling system clock
    // ------------------------------------------------------------
    // host drives mode and data, samples data out at the rise
    task automatic tick(input logic m, input logic d, output logic q);
        #50;
        tms = m;
        tdi = d;
        #50;
        tck = 1'b1;
        q = tdo;
        #100;
        tck = 1'b0;
    endtask

    // data in toggles outside shifts, so a held value proves nothing
    task automatic nav(input logic m);
        logic q;
        tick(m, ~tdi, q);
    endtask

    // five ones reach reset, then idle
    task automatic reset_tap();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask

    // scan from idle, lsb first, back to idle
    task automatic scan(input logic ir, input int len, input logic [133:0] din,
                        output logic [133:0] dout);
        dout = '0;
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < len; i++) tick(i == len - 1, din[i], dout[i]);
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the test access port
`include "jtd_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk, rst, tck, tms, tdi, tdo, tdo_oe, flash_busy;
    logic                     pins_driven, core_inputs_forced;
    logic [133:0]             bsr_capture, bsr_update, got;
    logic [17:0]              flash_rdata;
    logic [15:0]              tap_instruction;
    jtd_pkg::jtd_flash_req_t  flash_req, last_req;
    jtd_pkg::jtd_flash_regs_t flash_regs;
    int                       err_total = 0, total_checks = 0, cycles = 0, req_cnt = 0;

    jtd_tap i_jtd_tap (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .bsr_capture(bsr_capture), .bsr_update(bsr_update), .pins_driven(pins_driven),
        .core_inputs_forced(core_inputs_forced), .flash_rdata(flash_rdata),
        .flash_busy(flash_busy), .flash_req(flash_req), .flash_regs(flash_regs),
        .tap_instruction(tap_instruction)
    );
    jtd_host_model i_jtd_host_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // monitors and reporting
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (flash_req.valid === 1'b1) begin
            req_cnt++;
            last_req = flash_req;
        end
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("FAIL cycle_limit expected done seen hang");
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [133:0] seen, input logic [133:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic set_ir(input logic [15:0] code);
        i_jtd_host_model.scan(1'b1, 16, 134'(code), got);
        check("ir_capture", got[15:0], 16'h0001);
        check("ir", tap_instruction, code);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("ir_rst", tap_instruction, 16'h0000);
        check("pins_driven", pins_driven, 1'b1);
        check("forced", core_inputs_forced, 1'b1);
        check("tdo_oe", tdo_oe, 1'b0);
        check("req", flash_req, '0);
        i_jtd_host_model.reset_tap();
        check("ir_tms", tap_instruction, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_idcode();
        set_ir(16'h0004);
        check("pins_driven", pins_driven, 1'b0);
        // one extra bit shows the register is exactly 32 stages
        i_jtd_host_model.scan(1'b0, 33, 134'h1, got);
        check("idcode", got[32:0], {1'b1, `JTD_ID_VALUE});
        $display("test idcode done");
    endtask

    task automatic t_bypass();
        logic [15:0] codes [3];
        codes = '{16'hffff, 16'h0081, 16'h1234};
        foreach (codes[i]) begin
            set_ir(codes[i]);
            i_jtd_host_model.scan(1'b0, 8, 134'h5a, got);
            check("bypass", got[7:0], 8'hb4);
        end
        $display("test bypass done");
    endtask

    task automatic t_boundary();
        logic [133:0] cap, pat;
        logic [15:0]  codes [2];
        codes = '{16'h0002, 16'h0000};
        cap = {67{2'b01}};
        foreach (codes[i]) begin
            pat = ~cap ^ (134'h3 << (7 * i));
            @(negedge clk) bsr_capture = cap;
            set_ir(codes[i]);
            i_jtd_host_model.scan(1'b0, 134, pat, got);
            check("bsr_capture", got, cap);
            check("bsr_update", bsr_update, pat);
            check("pins_driven", pins_driven, codes[i] == 16'h0000);
            check("forced", core_inputs_forced, codes[i] == 16'h0000);
        end
        $display("test boundary done");
    endtask

    task automatic t_flash_data();
        int         n;
        logic [1:0] op;
        set_ir(16'h0083);
        // every operation code: write, read, both poll forms
        for (int k = 0; k < 4; k++) begin
            op = 2'(3 - k);
            n = req_cnt;
            @(negedge clk) flash_rdata = 18'h2c35a;
            flash_busy = k[0];
            i_jtd_host_model.scan(1'b0, 20, 134'({op, 18'h1d2b7}), got);
            check("fl_capture", got[19:0], {k[0], 1'b0, 18'h2c35a});
            check("req_count", 134'(req_cnt - n), 134'(op[1]));
            if (op[1]) check("req_kind", last_req[19:18], {1'b1, op[0]});
            if (op == 2'b11) check("req_data", last_req.wdata, 18'h1d2b7);
        end
        $display("test flash data done");
    endtask

    task automatic t_flash_regs();
        int           n;
        logic [17:0]  v, r;
        logic [15:0]  codes [3];
        codes = '{16'h0082, 16'h0084, 16'h0085};
        foreach (codes[i]) begin
            n = req_cnt;
            v = 18'h15a5a ^ 18'(i * 9);
            set_ir(codes[i]);
            i_jtd_host_model.scan(1'b0, 20, 134'({2'b11, v}), got);
            i_jtd_host_model.scan(1'b0, 20, 134'h0, got);
            r = i == 0 ? flash_regs.control : i == 1 ? flash_regs.address : flash_regs.scale;
            check("fl_reg_capture", got[19:0], {2'b00, v});
            check("fl_reg", r, v);
            check("req_count", 134'(req_cnt - n), 134'(0));
        end
        i_jtd_host_model.reset_tap();
        check("ir_tms", tap_instruction, 16'h0000);
        // reset in mid-run clears what the scans loaded
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        check("ir_after_rst", tap_instruction, 16'h0000);
        check("regs_after_rst", flash_regs, '0);
        $display("test flash registers done");
    endtask

    initial begin
        rst = 1'b1;
        bsr_capture = '0;
        flash_rdata = '0;
        flash_busy = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_reset();
        t_idcode();
        t_bypass();
        t_boundary();
        t_flash_data();
        t_flash_regs();
        print_verdict();
    end
endmodule
